/* core/twi_gate_defs.vh */
// Constants for the gated two-wire slave front end.
// Assumes a 50 MHz system clock; included by bare name.
`ifndef TWI_GATE_DEFS_VH
`define TWI_GATE_DEFS_VH
`define CLK_HZ 50000000
`define STARTUP_MS 60
`define WAKE_MS 50
`define STARTUP_CYC ((`CLK_HZ / 1000) * `STARTUP_MS)
`define WAKE_CYC ((`CLK_HZ / 1000) * `WAKE_MS)
`define PENALTY_FACTOR 4
`define CNT_W 32
`define SLAVE_ADDR_RST 7'h64
`define BIT_CNT_RST 4'h0
`define SHIFT_RST 8'h00
`endif

/* core/twi_slave_gate.v */
// Gated two-wire slave front end: readiness timers, sleep gating, byte engine.
// Assumes open-drain pins resolved outside; pins sampled on clk_sys_i.
`timescale 1ns/1ns
`default_nettype none
`include "twi_gate_defs.vh"
module twi_slave_gate
#(
	parameter STARTUP_CYC = `STARTUP_CYC,
	parameter WAKE_CYC = `WAKE_CYC
)
(
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire sleep_request_i,
	input wire penalty_pending_i,
	input wire [6:0] slave_addr_i,
	input wire scl_i,
	output wire scl_o,
	output wire scl_oe_n_o,
	input wire sda_i,
	output wire sda_o,
	output wire sda_oe_n_o,
	input wire [7:0] tx_data_i,
	output reg [7:0] rx_data_o,
	output reg rx_valid_o,
	output reg rx_first_o,
	output reg tx_req_o,
	output reg rd_mode_o,
	output reg stop_o,
	output wire ready_o,
	output wire asleep_o
);
	localparam [2:0] ST_WAIT = 3'b001;
	localparam [2:0] ST_READY = 3'b010;
	localparam [2:0] ST_SLEEP = 3'b100;
	localparam [4:0] B_IDLE = 5'b00001;
	localparam [4:0] B_SHIFT = 5'b00010;
	localparam [4:0] B_ACK = 5'b00100;
	localparam [4:0] B_SEND = 5'b01000;
	localparam [4:0] B_MACK = 5'b10000;
	localparam [`CNT_W-1:0] START_LEN = STARTUP_CYC;
	localparam [`CNT_W-1:0] WAKE_LEN = WAKE_CYC;
	localparam [`CNT_W-1:0] PEN_LEN = STARTUP_CYC * `PENALTY_FACTOR;

	wire scl_s;
	wire sda_s;
	wire slp_s;
	wire pen_s;
	reg scl_d_r;
	reg sda_d_r;
	reg [2:0] pw_state_r;
	reg [2:0] pw_state_nxt;
	reg [`CNT_W-1:0] wait_cnt_r;
	reg [`CNT_W-1:0] wait_cnt_nxt;
	reg first_wait_r;
	reg [4:0] b_state_r;
	reg [3:0] bit_cnt_r;
	reg [7:0] shift_r;
	reg addr_phase_r;
	reg sda_low_r;

	// Pins and the sleep and penalty inputs cross into the system clock with two flops each; slave_addr_i is used directly
	twi_sync2 #(.RST_VAL(1'b1)) u_sync_scl (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.async_i(scl_i), .sync_o(scl_s));
	twi_sync2 #(.RST_VAL(1'b1)) u_sync_sda (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.async_i(sda_i), .sync_o(sda_s));
	// Sleep and penalty idle low; a high reset level would fake a request
	twi_sync2 #(.RST_VAL(1'b0)) u_sync_slp (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.async_i(sleep_request_i), .sync_o(slp_s));
	twi_sync2 #(.RST_VAL(1'b0)) u_sync_pen (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.async_i(penalty_pending_i), .sync_o(pen_s));

	wire bus_on = (pw_state_r == ST_READY);
	wire scl_rise = bus_on & scl_s & ~scl_d_r;
	wire scl_fall = bus_on & ~scl_s & scl_d_r;
	wire start_ev = bus_on & scl_s & scl_d_r & sda_d_r & ~sda_s;
	wire stop_ev = bus_on & scl_s & scl_d_r & ~sda_d_r & sda_s;

	assign ready_o = bus_on;
	assign asleep_o = (pw_state_r == ST_SLEEP);
	// Clock line is input only; the master owns all clocking
	assign scl_o = 1'b1;
	assign scl_oe_n_o = 1'b1;
	// Open drain: drive low only when pulling, released otherwise
	assign sda_o = 1'b0;
	assign sda_oe_n_o = ~(sda_low_r & bus_on);

	// Readiness sequencer: start-up wait, sleep, wake-up wait
	always @*
	begin
		pw_state_nxt = pw_state_r;
		wait_cnt_nxt = wait_cnt_r;
		case (pw_state_r)
			ST_WAIT:
			begin
				if (slp_s)
					pw_state_nxt = ST_SLEEP;
				else if (wait_cnt_r == {`CNT_W{1'b0}})
					pw_state_nxt = ST_READY;
				else
					wait_cnt_nxt = wait_cnt_r - 1'b1;
			end
			ST_READY:
			begin
				// Bus traffic answered here until sleep is requested
				if (slp_s)
					pw_state_nxt = ST_SLEEP;
			end
			ST_SLEEP:
			begin
				if (!slp_s)
				begin
					// Wake timer starts at the falling edge of the request
					pw_state_nxt = ST_WAIT;
					wait_cnt_nxt = WAKE_LEN - 1'b1;
				end
			end
			default:
			begin
				pw_state_nxt = ST_WAIT;
				wait_cnt_nxt = START_LEN - 1'b1;
			end
		endcase
	end

	// Sequencer flops; clear works in every state, asleep or not
	always @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pw_state_r <= ST_WAIT;
			wait_cnt_r <= START_LEN - 1'b1;
			first_wait_r <= 1'b1;
		end
		else
		begin
			pw_state_r <= pw_state_nxt;
			// Penalty seen through the synchroniser reloads the start-up wait once
			if (first_wait_r && pen_s && pw_state_r == ST_WAIT)
				wait_cnt_r <= PEN_LEN - 1'b1;
			else
				wait_cnt_r <= wait_cnt_nxt;
			// Window closes on the reload or when the start-up wait is left
			first_wait_r <= first_wait_r & ~pen_s & (pw_state_r == ST_WAIT);
		end
	end

	// Byte engine: start, address, ack, data in both directions
	always @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			b_state_r <= B_IDLE;
			bit_cnt_r <= `BIT_CNT_RST;
			shift_r <= `SHIFT_RST;
			addr_phase_r <= 1'b0;
			sda_low_r <= 1'b0;
			rx_data_o <= 8'h00;
			rx_valid_o <= 1'b0;
			rx_first_o <= 1'b0;
			tx_req_o <= 1'b0;
			rd_mode_o <= 1'b0;
			stop_o <= 1'b0;
		end
		else
		begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
			rx_valid_o <= 1'b0;
			tx_req_o <= 1'b0;
			stop_o <= 1'b0;
			if (!bus_on)
			begin
				// Waiting or asleep: forget any transfer, drive nothing
				b_state_r <= B_IDLE;
				sda_low_r <= 1'b0;
				rx_first_o <= 1'b0;
				bit_cnt_r <= `BIT_CNT_RST;
			end
			else if (start_ev)
			begin
				// Start or repeated start from the master
				b_state_r <= B_SHIFT;
				bit_cnt_r <= `BIT_CNT_RST;
				addr_phase_r <= 1'b1;
				sda_low_r <= 1'b0;
				rx_first_o <= 1'b0;
			end
			else if (stop_ev)
			begin
				b_state_r <= B_IDLE;
				sda_low_r <= 1'b0;
				rx_first_o <= 1'b0;
				stop_o <= 1'b1;
			end
			else
			begin
				case (b_state_r)
					B_SHIFT:
					begin
						if (scl_rise)
						begin
							shift_r <= {shift_r[6:0], sda_s};
							bit_cnt_r <= bit_cnt_r + 4'h1;
						end
						else if (scl_fall && bit_cnt_r == 4'h8)
						begin
							bit_cnt_r <= `BIT_CNT_RST;
							if (addr_phase_r)
							begin
								addr_phase_r <= 1'b0;
								// Own address only; others left unanswered
								if (shift_r[7:1] == slave_addr_i)
								begin
									sda_low_r <= 1'b1;
									rd_mode_o <= shift_r[0];
									rx_first_o <= 1'b1;
									b_state_r <= B_ACK;
									tx_req_o <= shift_r[0];
								end
								else
									b_state_r <= B_IDLE;
							end
							else
							begin
								sda_low_r <= 1'b1;
								rx_data_o <= shift_r;
								rx_valid_o <= 1'b1;
								b_state_r <= B_ACK;
							end
						end
					end
					B_ACK:
					begin
						// Ack bit ends at the next falling clock edge
						if (scl_fall)
						begin
							if (rx_valid_o == 1'b0 && rd_mode_o)
							begin
								shift_r <= {tx_data_i[6:0], 1'b0};
								sda_low_r <= ~tx_data_i[7];
								bit_cnt_r <= 4'h1;
								b_state_r <= B_SEND;
							end
							else
							begin
								sda_low_r <= 1'b0;
								b_state_r <= B_SHIFT;
							end
							rx_first_o <= 1'b0;
						end
					end
					B_SEND:
					begin
						if (scl_fall)
						begin
							if (bit_cnt_r == 4'h8)
							begin
								sda_low_r <= 1'b0;
								b_state_r <= B_MACK;
							end
							else
							begin
								sda_low_r <= ~shift_r[7];
								shift_r <= {shift_r[6:0], 1'b0};
								bit_cnt_r <= bit_cnt_r + 4'h1;
							end
						end
					end
					B_MACK:
					begin
						// Master ack continues the read; nack releases the bus
						if (scl_rise)
						begin
							if (sda_s)
								b_state_r <= B_IDLE;
							else
								tx_req_o <= 1'b1;
						end
						else if (scl_fall)
						begin
							shift_r <= {tx_data_i[6:0], 1'b0};
							sda_low_r <= ~tx_data_i[7];
							bit_cnt_r <= 4'h1;
							b_state_r <= B_SEND;
						end
					end
					default:
						sda_low_r <= 1'b0;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

/* core/twi_sync2.v */
// Two-flop synchroniser for one level from outside the system clock domain.
// Assumes the input may change at any time relative to clk_sys_i.
`timescale 1ns/1ns
`default_nettype none
module twi_sync2
#(
	parameter [0:0] RST_VAL = 1'b1
)
(
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire async_i,
	output wire sync_o
);
	reg meta_r;
	reg sync_r;
	// First flop feeds only the second; reset level is the pin's idle level,
	// so no false edge or false request follows a clear
	always @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_r <= RST_VAL;
			sync_r <= RST_VAL;
		end
		else
		begin
			meta_r <= async_i;
			sync_r <= meta_r;
		end
	end
	assign sync_o = sync_r;
endmodule
`default_nettype wire

/* sim/test_twi_slave_gate.sv */
// Testbench for the gated two-wire slave front end.
// Assumes the master model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
	$display("CHECK FAILED %0t %h %h", $time, g, e); end end
module test_twi_slave_gate;
	localparam int S = 200;
	localparam int W = 100;
	localparam logic [6:0] ADR = 7'h3a;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic sleep = 1'b0;
	logic pen = 1'b0;
	logic [7:0] txd = 8'h96;
	logic scl, pull, ack, stopped, treq;
	wire logic treq_p, rdm;
	logic [7:0] q, rxb;
	wire logic scl_oe_n, sda_oe_n, rx_valid, stop_p, ready, asleep;
	wire logic [7:0] rxd;
	wire logic sda = !(pull || !sda_oe_n);
	wire logic scl_ln = scl && scl_oe_n;
	int fail_count = 0;
	int compares = 0;
	twi_master_model u_mst (.sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
	twi_slave_gate #(.STARTUP_CYC(S), .WAKE_CYC(W)) u_dut (.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i), .sleep_request_i(sleep), .penalty_pending_i(pen),
		.slave_addr_i(ADR), .scl_i(scl_ln), .scl_o(), .scl_oe_n_o(scl_oe_n), .sda_i(sda),
		.sda_o(), .sda_oe_n_o(sda_oe_n), .tx_data_i(txd), .rx_data_o(rxd),
		.rx_valid_o(rx_valid), .rx_first_o(), .tx_req_o(treq_p), .rd_mode_o(rdm),
		.stop_o(stop_p),
		.ready_o(ready), .asleep_o(asleep));
	always #10 clk_sys_i = !clk_sys_i;
	// Catch one-cycle pulses
	always @(posedge clk_sys_i)
	begin
		if (rx_valid)
			rxb <= rxd;
		if (stop_p)
			stopped <= 1'b1;
		if (treq_p)
			treq <= 1'b1;
	end
	task cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task go(input logic [6:0] a, input logic rd, input logic [7:0] d);
		stopped = 1'b0;
		treq = 1'b0;
		u_mst.xact(a, rd, d, ack, q);
		cyc(4);
	endtask
	task t_start;
		cyc(20);
		rst_n_i = 1'b1;
		go(ADR, 1'b0, 8'h00);
		`CHK(ack, 1'b1)
		cyc(S);
		`CHK(ready, 1'b1)
	endtask
	task t_rw;
		go(ADR, 1'b0, 8'hc3);
		`CHK({ack, rxb, stopped}, 10'h187)
		`CHK({rdm, treq}, 2'h0)
		go(ADR, 1'b1, 8'h00);
		`CHK({ack, q}, 9'h096)
		`CHK({rdm, treq}, 2'h3)
		go(ADR ^ 7'h01, 1'b0, 8'h55);
		`CHK(ack, 1'b1)
	endtask
	task t_sleep;
		sleep = 1'b1;
		cyc(5);
		`CHK(asleep, 1'b1)
		go(ADR, 1'b0, 8'h11);
		`CHK(ack, 1'b1)
		sleep = 1'b0;
		go(ADR, 1'b0, 8'h22);
		`CHK(ack, 1'b1)
		cyc(W);
		go(ADR, 1'b0, 8'h33);
		`CHK(rxb, 8'h33)
	endtask
	// Clear with sleep requested and a penalty pending
	task t_pen;
		rst_n_i = 1'b0;
		sleep = 1'b1;
		pen = 1'b1;
		cyc(20);
		`CHK({ready, asleep, sda_oe_n}, 3'h1)
		sleep = 1'b0;
		cyc(1);
		rst_n_i = 1'b1;
		cyc(S + 20);
		`CHK(ready, 1'b0)
		cyc(3 * S);
		`CHK(ready, 1'b1)
	endtask
	task wrap_up;
		if (fail_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		t_start;
		t_rw;
		t_sleep;
		t_pen;
		wrap_up;
	end
	// Hang guard, well past the expected run
	initial
	begin
		#200000;
		fail_count++;
		wrap_up;
	end
endmodule
`default_nettype wire

/* sim/twi_master_model.sv */
// Bus master model: starts, stops, all clocking, bytes.
// Assumes a pulled-up data wire; clock stands high between frames.
`timescale 1ns/1ns
`default_nettype none
module twi_master_model
(
	input wire logic sda_i,
	output var logic scl_o,
	output var logic sda_pull_o
);
	// Idle bus
	initial
	begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end
	// 160 ns bit; data moves only while clock low, sampled late in high
	task bit_io(input logic b, output logic r);
	begin
		#20 sda_pull_o = !b;
		#60 scl_o = 1'b1;
		#60 r = sda_i;
		#20 scl_o = 1'b0;
	end
	endtask
	task byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
		int i;
	begin
		for (i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(1'b1, ack);
	end
	endtask
	// Start, address, one byte unless refused, stop
	task xact(input logic [6:0] a, input logic rd, input logic [7:0] d,
		output logic ack, output logic [7:0] q);
		logic k;
	begin
		sda_pull_o = 1'b1;
		#80 scl_o = 1'b0;
		byte_io({a, rd}, q, ack);
		if (!ack)
			byte_io(rd ? 8'hff : d, q, k);
		#20 sda_pull_o = 1'b1;
		#60 scl_o = 1'b1;
		#80 sda_pull_o = 1'b0;
		#80;
	end
	endtask
endmodule
`default_nettype wire

/* sim/twi_slave_gate_monitor.sv */
// Checker for the gated two-wire slave front end.
// Assumes bind to twi_slave_gate with shortened timers.
`timescale 1ns/1ns
`default_nettype none
module twi_gate_mon
#(
	parameter STARTUP_CYC = 200,
	parameter WAKE_CYC = 100
)
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic sleep_request_i,
	input wire logic penalty_pending_i,
	input wire logic scl_oe_n_o,
	input wire logic sda_oe_n_o,
	input wire logic rx_valid_o,
	input wire logic rx_first_o,
	input wire logic ready_o,
	input wire logic asleep_o
);
	int up_r;
	int low_r;
	logic woke_r;
	int lim;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	// Cycles since release and since sleep fell; slack covers the synchronisers
	always @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			up_r <= 0;
			low_r <= 0;
			woke_r <= 1'b0;
		end
		else
		begin
			up_r <= up_r + 1;
			low_r <= sleep_request_i ? 0 : low_r + 1;
			woke_r <= woke_r | sleep_request_i;
		end
	end
	// Penalty stretches the wait fourfold
	assign lim = penalty_pending_i ? 4 * STARTUP_CYC : STARTUP_CYC;
	sequence s_up;
		$rose(ready_o);
	endsequence
	property p_start;
		s_up ##0 !woke_r |-> up_r >= lim - 2 && up_r <= lim + 6;
	endproperty
	property p_wake;
		s_up ##0 woke_r |-> low_r >= WAKE_CYC - 2 && low_r <= WAKE_CYC + 6;
	endproperty
	property p_awake;
		woke_r && !sleep_request_i && low_r == WAKE_CYC + 8 |-> ready_o;
	endproperty
	property p_sleep;
		sleep_request_i [*5] |-> asleep_o && !ready_o;
	endproperty
	property p_deaf;
		!ready_o |-> sda_oe_n_o;
	endproperty
	property p_scl;
		1'b1 |-> scl_oe_n_o;
	endproperty
	property p_ack;
		$rose(rx_first_o) |-> ##[0:2] !sda_oe_n_o;
	endproperty
	property p_pulse;
		rx_valid_o |=> !rx_valid_o;
	endproperty
	a_start: assert property (p_start) else $error("start wait");
	a_wake: assert property (p_wake) else $error("wake wait");
	a_awake: assert property (p_awake) else $error("not awake");
	a_sleep: assert property (p_sleep) else $error("no sleep");
	a_deaf: assert property (p_deaf) else $error("drove data");
	a_scl: assert property (p_scl) else $error("clock held");
	a_ack: assert property (p_ack) else $error("no ack");
	a_pulse: assert property (p_pulse) else $error("long pulse");
endmodule
bind twi_slave_gate twi_gate_mon #(.STARTUP_CYC(STARTUP_CYC), .WAKE_CYC(WAKE_CYC)) u_mon (
	.clk_sys_i(clk_sys_i),
	.rst_n_i(rst_n_i),
	.sleep_request_i(sleep_request_i),
	.penalty_pending_i(penalty_pending_i),
	.scl_oe_n_o(scl_oe_n_o),
	.sda_oe_n_o(sda_oe_n_o),
	.rx_valid_o(rx_valid_o),
	.rx_first_o(rx_first_o),
	.ready_o(ready_o),
	.asleep_o(asleep_o)
);
`default_nettype wire
